//--- logic/acrs_pkg.sv
// Purpose: Shared constants, types and helpers for the clock generator 3 reference selector.
// Assumes: Registers are 16 bits wide and sit in the low half of a 32-bit Wishbone word.
// Notes: Register indices are word indices; the byte address is four times the index.
package acrs_pkg;
    localparam int WB_ADR_W = 18;
    localparam int NUM_MP = 10;
    localparam int REG_W = 16;
    // Register indices.
    localparam logic [15:0] DENOM_IDX = 16'hf024;
    localparam logic [15:0] NUMER_IDX = 16'hf025;
    localparam logic [15:0] SRC_IDX = 16'hf026;
    localparam logic [15:0] STATUS_IDX = 16'hf027;
    // Reset values.
    localparam logic [15:0] DENOM_RESET = 16'h0000;
    localparam logic [15:0] NUMER_RESET = 16'h0000;
    localparam logic [15:0] SRC_RESET = 16'h000e;
    // Field layout of the reference source register.
    localparam int SRC_EXT_BIT = 4;
    localparam int SRC_PIN_LSB = 0;
    localparam int SRC_PIN_W = 4;
    localparam logic [15:0] SRC_WMASK = 16'h001f;
    // Field layout of the status register.
    localparam int STAT_EXT_BIT = 0;
    localparam int STAT_ABSENT_BIT = 1;
    localparam int STAT_LEVEL_BIT = 2;
    // Reference pin codes.
    localparam logic [3:0] PIN_LAST_MP = 4'h9;
    localparam logic [3:0] PIN_RX_CODE = 4'he;
    // Divisor applied to the numerator when an external reference is used.
    localparam logic [16:0] EXT_MODULUS = 17'h00400;

    typedef struct packed {
        logic extRef;
        logic [SRC_PIN_W-1:0] refPin;
    } acrs_ctrl_t;

    typedef struct packed {
        logic valid;
        logic isRx;
        logic [3:0] mpIdx;
    } acrs_route_t;

    function automatic logic [WB_ADR_W-1:0] acrs_byte_adr(input logic [15:0] idx);
        acrs_byte_adr = {idx, 2'b00};
    endfunction : acrs_byte_adr

    function automatic acrs_route_t acrs_decode(input logic [3:0] code);
        acrs_route_t r;
        r = '0;
        if (code <= PIN_LAST_MP) begin
            r.valid = 1'b1;
            r.mpIdx = code;
        end else if (code == PIN_RX_CODE) begin
            r.valid = 1'b1;
            r.isRx = 1'b1;
        end
        acrs_decode = r;
    endfunction : acrs_decode

    function automatic logic [15:0] acrs_merge(input logic [15:0] old, input logic [15:0] wdat,
                                               input logic [1:0] sel);
        acrs_merge = {sel[1] ? wdat[15:8] : old[15:8], sel[0] ? wdat[7:0] : old[7:0]};
    endfunction : acrs_merge
endpackage : acrs_pkg

//--- logic/acrs_rate_acc.sv
// Purpose: Fractional rate accumulator that turns added increments into base rate ticks.
// Assumes: At most one tick leaves per cycle; excess stays in the accumulator.
// Notes: A zero modulus stops all ticks.
`timescale 1ns/1ps
`default_nettype none
module acrs_rate_acc #(
    parameter int ACC_W = 20
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Control.
    input wire logic clr,
    input wire logic addEn,
    input wire logic [15:0] addVal,
    input wire logic [16:0] modulus,
    // Output.
    output logic tick
);
    logic [ACC_W-1:0] acc_r;
    logic [ACC_W-1:0] acc_nxt;
    logic [ACC_W:0] sum;
    logic [ACC_W-1:0] held;
    logic tick_nxt;

    // The sum saturates so a fast internal increment cannot wrap the count.
    always_comb begin
        sum = {1'b0, acc_r} + (addEn ? (ACC_W+1)'(addVal) : '0);
        held = sum[ACC_W] ? '1 : sum[ACC_W-1:0];
        tick_nxt = 1'b0;
        acc_nxt = held;
        if (modulus != 17'h00000 && held >= ACC_W'(modulus)) begin
            tick_nxt = 1'b1;
            acc_nxt = held - ACC_W'(modulus);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_r <= '0;
        end else if (clr) begin
            acc_r <= '0;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick <= 1'b0;
        end else begin
            tick <= tick_nxt & ~clr;
        end
    end

    a_tick_needs_mod: assert property (@(posedge sys_clk) disable iff (!rst_b) tick |-> $past(modulus) != 17'h00000)
        else $error("tick with zero modulus");
    a_no_tick_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !addEn && acc_r == '0 |=> !tick)
        else $error("tick with nothing accumulated");
endmodule : acrs_rate_acc
`default_nettype wire

//--- logic/acrs_clkgen3_ref.sv
// Purpose: Reference source selection and base rate generation for clock generator 3.
// Assumes: Classic Wishbone slave, 32-bit data, registers in the low 16 bits.
// Notes: Reference pins are asynchronous and pass two flip-flops before use.
// Behaviour
// - Bit 4 of the reference source register picks the PLL (clear) or an external pin (set) as reference.
// - With the PLL as reference the base rate is the system clock scaled by numerator over denominator.
// - With an external reference the base rate is its frequency times the numerator over 1024, denominator ignored.
// - Bits 3:0 choose the external reference input and reset to 0xE.
// - Code 0000 routes multipurpose pin 0 and code 0001 routes multipurpose pin 1.
// - Code 1110 routes the audio receiver sample clock, so 48 kHz with numerator 2048 gives 96 kHz.
// - The reference source register resets to 0x000E with bits 15:5 reserved as zero.
// - Codes 0010 to 1001 route multipurpose pins 2 to 9 in order.
// - The numerator is a 16-bit unsigned integer feeding the rate in both modes.
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module acrs_clkgen3_ref
    import acrs_pkg::*;
#(
    parameter int ACC_W = 20
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Reference inputs.
    input wire logic [NUM_MP-1:0] multipurposePin,
    input wire logic rxSampleClk,
    // Generator outputs.
    output logic baseRateTick,
    output logic extRefActive,
    output logic refAbsent
);
    localparam int NSYNC = NUM_MP + 1;

    logic [15:0] srcReg_r;
    logic [15:0] numer_r;
    logic [15:0] denom_r;
    acrs_ctrl_t ctrl;
    acrs_ctrl_t ctrlPrev_r;
    acrs_route_t route;
    logic reqNew;
    logic wrTake;
    logic [NSYNC-1:0] sync1_r;
    logic [NSYNC-1:0] sync2_r;
    logic [NSYNC-1:0] sync3_r;
    logic selLevel;
    logic selPrev;
    logic refEdge;
    logic extMode;
    logic addEn;
    logic [16:0] modulus;
    logic clr;
    logic [31:0] rdData;

    // Bus handshake: ack one cycle after the request, dropped the cycle after.
    assign reqNew = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wrTake = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= reqNew;
        end
    end

    // Unmapped addresses read as zero and ignore writes.
    always_comb begin
        rdData = 32'h00000000;
        if (wb_adr_i == acrs_byte_adr(SRC_IDX)) begin
            rdData[15:0] = srcReg_r;
        end else if (wb_adr_i == acrs_byte_adr(NUMER_IDX)) begin
            rdData[15:0] = numer_r;
        end else if (wb_adr_i == acrs_byte_adr(DENOM_IDX)) begin
            rdData[15:0] = denom_r;
        end else if (wb_adr_i == acrs_byte_adr(STATUS_IDX)) begin
            rdData[STAT_EXT_BIT] = extMode;
            rdData[STAT_ABSENT_BIT] = refAbsent;
            rdData[STAT_LEVEL_BIT] = selLevel;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_dat_o <= 32'h00000000;
        end else if (reqNew && !wb_we_i) begin
            wb_dat_o <= rdData;
        end
    end

    // Reserved bits are masked so they always read back as zero.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            srcReg_r <= SRC_RESET;
        end else if (wrTake && wb_adr_i == acrs_byte_adr(SRC_IDX)) begin
            srcReg_r <= acrs_merge(srcReg_r, wb_dat_i[15:0], wb_sel_i[1:0]) & SRC_WMASK;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            numer_r <= NUMER_RESET;
        end else if (wrTake && wb_adr_i == acrs_byte_adr(NUMER_IDX)) begin
            numer_r <= acrs_merge(numer_r, wb_dat_i[15:0], wb_sel_i[1:0]);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            denom_r <= DENOM_RESET;
        end else if (wrTake && wb_adr_i == acrs_byte_adr(DENOM_IDX)) begin
            denom_r <= acrs_merge(denom_r, wb_dat_i[15:0], wb_sel_i[1:0]);
        end
    end

    // Control fields and input routing.
    assign ctrl = acrs_ctrl_t'(srcReg_r[SRC_EXT_BIT:SRC_PIN_LSB]);
    assign extMode = ctrl.extRef;
    assign route = acrs_decode(ctrl.refPin);

    // Reference inputs are resynchronised; edges are seen between stages two and three.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end else begin
            sync1_r <= {rxSampleClk, multipurposePin};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    always_comb begin
        selLevel = 1'b0;
        selPrev = 1'b0;
        if (route.isRx) begin
            selLevel = sync2_r[NUM_MP];
            selPrev = sync3_r[NUM_MP];
        end else if (route.valid) begin
            selLevel = sync2_r[route.mpIdx];
            selPrev = sync3_r[route.mpIdx];
        end
    end

    // Only the rising edge counts, so the duty cycle of the source does not matter.
    assign refEdge = selLevel & ~selPrev;

    // The PLL path adds the numerator every system clock; the external path once per reference edge.
    assign addEn = extMode ? (route.valid & refEdge) : 1'b1;
    assign modulus = extMode ? EXT_MODULUS : {1'b0, denom_r};

    // Any change of source restarts the accumulator so no stale fraction leaks across.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrlPrev_r <= acrs_ctrl_t'(SRC_RESET[SRC_EXT_BIT:SRC_PIN_LSB]);
        end else begin
            ctrlPrev_r <= ctrl;
        end
    end

    assign clr = (ctrl != ctrlPrev_r);

    acrs_rate_acc #(
        .ACC_W(ACC_W)
    ) u_rate_acc (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clr(clr),
        .addEn(addEn),
        .addVal(numer_r),
        .modulus(modulus),
        .tick(baseRateTick)
    );

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            extRefActive <= 1'b0;
            refAbsent <= 1'b0;
        end else begin
            extRefActive <= extMode;
            refAbsent <= extMode & ~route.valid;
        end
    end

    sequence s_srcWrite;
        wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == acrs_byte_adr(SRC_IDX);
    endsequence

    sequence s_busReq;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    // Writes of the rate registers are seen at the acknowledging edge, reads at the request edge.
    sequence s_numerWrite;
        wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == acrs_byte_adr(NUMER_IDX);
    endsequence

    sequence s_denomWrite;
        wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == acrs_byte_adr(DENOM_IDX);
    endsequence

    sequence s_busRead;
        wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    endsequence

    // An increment that reaches the modulus by itself must leave a tick in the next cycle.
    sequence s_pllFull;
        !extMode && denom_r != 16'h0000 && numer_r >= denom_r && !clr;
    endsequence

    sequence s_extFull;
        extMode && route.valid && refEdge && {1'b0, numer_r} >= EXT_MODULUS && !clr;
    endsequence

    a_reset_value: assert property (@(posedge sys_clk) !rst_b |=> srcReg_r == SRC_RESET)
        else $error("source register reset value wrong");
    a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_b) srcReg_r[15:5] == 11'h000)
        else $error("reserved source bits not zero");
    a_src_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_srcWrite ##0 wb_sel_i[1:0] == 2'h3 |=> srcReg_r == ($past(wb_dat_i[15:0]) & SRC_WMASK))
        else $error("source register write lost");
    a_ack_one_cycle: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_busReq |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle");
    a_mode_follow: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $changed(srcReg_r[SRC_EXT_BIT]) |=> extRefActive == $past(srcReg_r[SRC_EXT_BIT]))
        else $error("mode output does not follow control bit");
    a_pll_path: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !extMode |-> addEn && modulus == {1'b0, denom_r})
        else $error("PLL path not scaled by denominator");
    a_ext_path: assert property (@(posedge sys_clk) disable iff (!rst_b)
        extMode |-> modulus == EXT_MODULUS && addEn == (route.valid && refEdge))
        else $error("external path not scaled by 1024");
    a_pin_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ctrl.refPin <= 4'h1 |-> selLevel == sync2_r[ctrl.refPin])
        else $error("pin 0 or 1 not routed");
    a_rx_route: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ctrl.refPin == PIN_RX_CODE |-> selLevel == sync2_r[NUM_MP])
        else $error("receiver clock not routed");
    a_pin_range: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ctrl.refPin >= 4'h2 && ctrl.refPin <= PIN_LAST_MP |-> selLevel == sync2_r[ctrl.refPin])
        else $error("pins 2 to 9 not routed");
    a_numer_feed: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_pllFull |=> baseRateTick)
        else $error("numerator not fed to the accumulator");
    a_absent_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
        extMode && !route.valid |-> !addEn ##1 refAbsent)
        else $error("absent reference still counted");

    // Register file and bus read path.
    a_numer_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_numerWrite ##0 wb_sel_i[1:0] == 2'h3 |=> numer_r == $past(wb_dat_i[15:0]))
        else $error("numerator write lost");
    // A write of the high byte alone must leave the low byte as it was.
    a_numer_byte: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_numerWrite ##0 wb_sel_i[1:0] == 2'h2 |=> numer_r == {$past(wb_dat_i[15:8]), $past(numer_r[7:0])})
        else $error("numerator byte lanes mixed");
    a_denom_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_denomWrite ##0 wb_sel_i[1:0] == 2'h3 |=> denom_r == $past(wb_dat_i[15:0]))
        else $error("denominator write lost");
    // Read data is captured from the address that the request carried.
    a_read_data: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_busRead |=> wb_dat_o == $past(rdData))
        else $error("read data not taken from the addressed register");
    // The bus answers only a request that was pending in the cycle before.
    a_ack_needs_req: assert property (@(posedge sys_clk) disable iff (!rst_b)
        wb_ack_o |-> $past(reqNew))
        else $error("bus ack without a request");

    // Rate generation in both modes.
    // An increment of 1024 or more is a whole base period in itself.
    a_ext_tick: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_extFull |=> baseRateTick)
        else $error("external increment of 1024 or more gave no tick");
    // A zero denominator stops the internal path altogether.
    a_pll_silent: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !extMode && denom_r == 16'h0000 |=> !baseRateTick)
        else $error("tick with a zero denominator");
    // The mode output lags the control bit by exactly one register.
    a_mode_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
        extRefActive == $past(extMode))
        else $error("mode output not one cycle behind the control bit");

    // A source change or an absent reference keeps the generator quiet.
    a_clr_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clr |=> !baseRateTick)
        else $error("tick in the cycle after a source change");
    a_absent_silent: assert property (@(posedge sys_clk) disable iff (!rst_b)
        extMode && !route.valid |=> !baseRateTick)
        else $error("tick from an unassigned reference code");
    // Leaving external mode clears the absent flag one cycle later.
    a_absent_follow: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !extMode |=> !refAbsent)
        else $error("absent flag set in internal mode");
endmodule : acrs_clkgen3_ref
`default_nettype wire

//--- testbench/acrs_ref_model.sv
// Purpose: Model of the outside reference clock source for clock generator 3.
// Assumes: Driven from the system clock; one line at a time carries the reference.
// Notes: Lines not carrying the reference toggle every three cycles as noise.
`timescale 1ns/1ps
`default_nettype none
module acrs_ref_model #(
    parameter int HALF = 4
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_b,
    // Control.
    input wire logic run,
    input wire logic [3:0] code,
    // Reference lines.
    output logic [9:0] multipurposePin,
    output logic rxSampleClk
);
    int unsigned halfCnt;
    int unsigned noiseCnt;
    logic refLvl;
    logic noise;
    // Square wave with equal halves while running; a stopped source holds its line low.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            halfCnt <= 0;
            refLvl <= 1'b0;
        end else if (!run) begin
            halfCnt <= 0;
            refLvl <= 1'b0;
        end else if (halfCnt == HALF - 1) begin
            halfCnt <= 0;
            refLvl <= ~refLvl;
        end else begin
            halfCnt <= halfCnt + 1;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            noiseCnt <= 0;
            noise <= 1'b0;
        end else begin
            noiseCnt <= (noiseCnt == 2) ? 0 : noiseCnt + 1;
            noise <= (noiseCnt == 2) ? ~noise : noise;
        end
    end
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            multipurposePin[i] = (code == 4'(i)) ? refLvl : noise;
        end
        rxSampleClk = (code == 4'he) ? refLvl : noise;
    end
endmodule : acrs_ref_model
`default_nettype wire

//--- testbench/testbench.sv
// Purpose: Self-checking bench for the clock generator 3 reference selector.
// Assumes: Classic Wishbone master; outside references come from acrs_ref_model.
// Notes: Tick counts are compared with the counts worked out from numerator and denominator, or from numerator over 1024 in external mode.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import acrs_pkg::*;
    localparam int HALF = 4;
    localparam int PER = 8;
    localparam int CYC = 200;
    localparam int LIMIT = 20000;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [WB_ADR_W-1:0] adr = '0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack, tick, extAct, absent, rxClk;
    logic run = 1'b0;
    logic [3:0] code = 4'hf;
    logic [9:0] mpPin;
    int mismatches = 0;
    int nChecks = 0;
    int ticks = 0;
    int cycles = 0;

    always #25 sys_clk = ~sys_clk;

    acrs_clkgen3_ref i_acrs_clkgen3_ref (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .multipurposePin(mpPin), .rxSampleClk(rxClk), .baseRateTick(tick), .extRefActive(extAct),
        .refAbsent(absent));
    acrs_ref_model #(.HALF(HALF)) i_acrs_ref_model (.sys_clk(sys_clk), .rst_b(rst_b), .run(run),
        .code(code), .multipurposePin(mpPin), .rxSampleClk(rxClk));

    task automatic wrapUp;
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrapUp

    always @(posedge sys_clk) begin
        ticks <= ticks + ((tick === 1'b1) ? 1 : 0);
        cycles = cycles + 1;
        if (cycles == LIMIT) begin
            mismatches = mismatches + 1;
            wrapUp();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        nChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic wb(input logic w, input logic [15:0] idx, input logic [15:0] d, input logic [3:0] s,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= s;
        wdat <= {16'h0000, d};
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1);
        q = rdat;
        check(32'(n), 32'h2, "bus answer delay");
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge sys_clk);
    endtask : wb

    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, 4'h3, q);
    endtask : wr

    task automatic rdChk(input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, idx, 16'h0000, 4'hf, q);
        check(q, exp, "register read");
    endtask : rdChk

    task automatic doReset;
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
    endtask : doReset

    task automatic intRun(input int m, input int n);
        int t0;
        int e;
        int got;
        wr(DENOM_IDX, 16'(m));
        wr(NUMER_IDX, 16'(n));
        wr(SRC_IDX, 16'h001a);
        wr(SRC_IDX, 16'h0000);
        t0 = ticks;
        repeat (CYC) @(posedge sys_clk);
        got = ticks - t0;
        e = (m == 0) ? 0 : ((n >= m) ? CYC : CYC * n / m);
        check(32'(got >= e - 2 && got <= e + 2), 32'h1, "internal tick count");
        check(32'(extAct), 32'h0, "external flag");
        $display("test internal m %0d n %0d done", m, n);
    endtask : intRun

    task automatic extRun(input logic [3:0] c, input int n);
        int t0;
        logic ok;
        ok = (c <= 4'h9) || (c == 4'he);
        wr(NUMER_IDX, 16'(n));
        code <= c;
        wr(SRC_IDX, {11'h000, 1'b1, c});
        repeat (2) @(posedge sys_clk);
        check(32'(extAct), 32'h1, "external flag");
        check(32'(absent), 32'(!ok), "absent flag");
        rdChk(STATUS_IDX, {29'h0, 1'b0, !ok, 1'b1});
        t0 = ticks;
        run <= 1'b1;
        repeat (2 * HALF * PER) @(posedge sys_clk);
        run <= 1'b0;
        repeat (12) @(posedge sys_clk);
        check(32'(ticks - t0), ok ? 32'(PER * n / 1024) : 32'h0, "external tick count");
        $display("test external code %h n %0d done", c, n);
    endtask : extRun

    initial begin
        logic [31:0] q;
        int m;
        void'($urandom(32'ha8a267eb));
        doReset();
        rdChk(SRC_IDX, 32'h0000000e);
        rdChk(NUMER_IDX, 32'h00000000);
        rdChk(DENOM_IDX, 32'h00000000);
        wr(SRC_IDX, 16'hffff);
        rdChk(SRC_IDX, 32'h0000001f);
        wr(NUMER_IDX, 16'h1234);
        wb(1'b1, NUMER_IDX, 16'habcd, 4'h2, q);
        rdChk(NUMER_IDX, 32'h0000ab34);
        m = $urandom_range(16'hffff);
        wr(NUMER_IDX, 16'(m));
        rdChk(NUMER_IDX, 32'(m));
        wr(16'hf028, 16'h5555);
        rdChk(16'hf028, 32'h00000000);
        $display("test registers done");
        intRun(0, 5);
        intRun(100, 100);
        repeat (4) begin
            m = 1 + $urandom_range(999);
            intRun(m, $urandom_range(m));
        end
        wr(DENOM_IDX, 16'(1 + $urandom_range(999)));
        extRun(4'h0, 1024);
        extRun(4'h1, 1024);
        extRun(4'he, 2048);
        for (int c = 0; c < 16; c++) begin
            extRun(4'(c), $urandom_range(4095));
        end
        doReset();
        rdChk(SRC_IDX, 32'h0000000e);
        check(32'(extAct), 32'h0, "external flag after reset");
        check(32'(absent), 32'h0, "absent flag after reset");
        $display("test second reset done");
        wrapUp();
    end
endmodule : testbench
`default_nettype wire
